// *** logic/cms_defs.svh ***
// constants for the combiner matrix serial control block
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH

// ==========================================================
// geometry
`define CMS_NUM_OUTPUTS 16
`define CMS_SEL_BITS 2
`define CMS_FRAME_BITS 32
`define CMS_COUNT_BITS 6
`define CMS_NUM_CARDS 3

// ==========================================================
// select codes, two bits per output
`define CMS_SEL_LOW_FEED 2'h0
`define CMS_SEL_MID_FEED 2'h1
`define CMS_SEL_HIGH_FEED 2'h2
`define CMS_SEL_GROUND 2'h3

// ==========================================================
// reset values
`define CMS_SELECT_RESET 32'hFFFFFFFF
`define CMS_COUNT_RESET 6'h00

// ==========================================================
// position identifiers handed to the three crosspoint cards
`define CMS_CARD0_ID 2'h0
`define CMS_CARD1_ID 2'h1
`define CMS_CARD2_ID 2'h2

`endif

// *** logic/cms_pkg.sv ***
// types shared by the combiner matrix serial control block
`include "cms_defs.svh"

package cms_pkg;

  // ==========================================================
  // buffered control link handed on to each crosspoint card
  typedef struct packed
  {
    logic data;
    logic clock;
    logic strobe;
    logic vertical_trigger;
  } cms_link_s;

  // ==========================================================
  // frame tracking states, one-hot
  typedef enum logic [1:0]
  {
    CMS_ST_IDLE = 2'h1,
    CMS_ST_SHIFT = 2'h2
  } cms_state_e;

  typedef logic [`CMS_SEL_BITS-1:0] cms_sel_t;
  typedef logic [`CMS_FRAME_BITS-1:0] cms_frame_t;

endpackage : cms_pkg

// *** logic/cms_select_store.sv ***
// serial-to-parallel selector store with vertical-trigger transfer
`include "cms_defs.svh"

module cms_select_store
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_shift_pulse,
  input wire logic i_shift_bit,
  input wire logic i_transfer,
  output cms_pkg::cms_frame_t o_select
);
  import cms_pkg::*;

  cms_frame_t shift_reg;
  cms_frame_t shift_next;
  cms_frame_t hold_reg;
  cms_frame_t hold_next;

  // ==========================================================
  // next values: shift on each local pulse, transfer on trigger
  always_comb
  begin
    shift_next = shift_reg;
    hold_next = hold_reg;
    if (i_shift_pulse)
    begin
      shift_next = {shift_reg[`CMS_FRAME_BITS-2:0], i_shift_bit};
    end
    if (i_transfer)
    begin
      hold_next = shift_reg;
    end
  end

  // ==========================================================
  // registers; hold resets to all-ground so no feed leaks out
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      shift_reg <= `CMS_SELECT_RESET;
      hold_reg <= `CMS_SELECT_RESET;
    end
    else
    begin
      shift_reg <= shift_next;
      hold_reg <= hold_next;
    end
  end

  assign o_select = hold_reg;

endmodule : cms_select_store

// *** logic/cms_matrix_control.sv ***
// combiner matrix serial control: stream decode, selectors, card fan-out
//
// Overview of operation
// - derive local shift pulses from serial stream
// - accumulate serially, update outputs on vertical trigger
// - per-output 4:1 selector over three feeds
// - two select bits choose selector input
// - unselected output steered to grounded fourth input
// - buffer four control signals to three cards
// - distinct 2-bit position id per card
`include "cms_defs.svh"

module cms_matrix_control
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ctl_serial_data,
  input wire logic i_ctl_serial_clock,
  input wire logic i_ctl_serial_strobe,
  input wire logic i_vertical_trigger,
  input wire logic [`CMS_NUM_OUTPUTS-1:0] i_feed_low_range,
  input wire logic [`CMS_NUM_OUTPUTS-1:0] i_feed_mid_range,
  input wire logic [`CMS_NUM_OUTPUTS-1:0] i_feed_high_range,
  output logic [`CMS_NUM_OUTPUTS-1:0] o_combined_out,
  output logic [`CMS_NUM_OUTPUTS-1:0] o_out_select_bit0,
  output logic [`CMS_NUM_OUTPUTS-1:0] o_out_select_bit1,
  output logic o_selector_shift_clock,
  output logic o_frame_active,
  output logic [`CMS_COUNT_BITS-1:0] o_frame_bit_count,
  output cms_pkg::cms_link_s [`CMS_NUM_CARDS-1:0] o_card_link,
  output logic [`CMS_NUM_CARDS-1:0][1:0] o_card_position_id
);
  import cms_pkg::*;

  // ==========================================================
  // pin synchronisers: stage one is read only by stage two
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync_prev_reg;
  logic data_s;
  logic clock_s;
  logic strobe_s;
  logic vt_s;

  // two flops per pin, then one more to find edges
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync_prev_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= {i_vertical_trigger, i_ctl_serial_strobe, i_ctl_serial_clock,
        i_ctl_serial_data};
      sync2_reg <= sync1_reg;
      sync_prev_reg <= sync2_reg;
    end
  end

  assign data_s = sync2_reg[0];
  assign clock_s = sync2_reg[1];
  assign strobe_s = sync2_reg[2];
  assign vt_s = sync2_reg[3];

  // ==========================================================
  // frame tracking and local shift clock
  cms_state_e state_reg;
  cms_state_e state_next;
  logic [`CMS_COUNT_BITS-1:0] count_reg;
  logic [`CMS_COUNT_BITS-1:0] count_next;
  logic shift_pulse_reg;
  logic shift_pulse_next;
  logic shift_bit_reg;
  logic shift_bit_next;
  logic clock_rise;
  logic vt_rise;

  assign clock_rise = clock_s & ~sync_prev_reg[1];
  // a trigger edge mid-frame still transfers; the processor times it
  assign vt_rise = vt_s & ~sync_prev_reg[3];

  // next state; clock edges outside a strobe frame are ignored
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    shift_pulse_next = 1'b0;
    shift_bit_next = shift_bit_reg;
    case (state_reg)
      CMS_ST_IDLE:
      begin
        count_next = `CMS_COUNT_RESET;
        if (strobe_s)
        begin
          state_next = CMS_ST_SHIFT;
        end
      end
      CMS_ST_SHIFT:
      begin
        if (!strobe_s)
        begin
          state_next = CMS_ST_IDLE;
        end
        else if (clock_rise)
        begin
          shift_pulse_next = 1'b1;
          shift_bit_next = data_s;
          if (count_reg != 6'(`CMS_FRAME_BITS))
          begin
            count_next = count_reg + 6'h01;
          end
        end
      end
      default:
      begin
        state_next = CMS_ST_IDLE;
        count_next = `CMS_COUNT_RESET;
      end
    endcase
  end

  // register the frame tracker
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      state_reg <= CMS_ST_IDLE;
      count_reg <= `CMS_COUNT_RESET;
      shift_pulse_reg <= 1'b0;
      shift_bit_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      shift_pulse_reg <= shift_pulse_next;
      shift_bit_reg <= shift_bit_next;
    end
  end

  // ==========================================================
  // selector control store
  cms_frame_t select_word;
  logic vt_pulse_reg;
  logic vt_pulse_next;

  // delay the trigger one cycle so a last bit in flight lands first
  assign vt_pulse_next = vt_rise;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      vt_pulse_reg <= 1'b0;
    end
    else
    begin
      vt_pulse_reg <= vt_pulse_next;
    end
  end

  cms_select_store u_store
  (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_shift_pulse(shift_pulse_reg),
    .i_shift_bit(shift_bit_reg),
    .i_transfer(vt_pulse_reg),
    .o_select(select_word)
  );

  // ==========================================================
  // per-output 4:1 selectors; output 15 is sent first, so sits on top
  logic [`CMS_NUM_OUTPUTS-1:0] comb_out_next;
  logic [`CMS_NUM_OUTPUTS-1:0] comb_out_reg;
  logic [`CMS_NUM_OUTPUTS-1:0] sel0_wire;
  logic [`CMS_NUM_OUTPUTS-1:0] sel1_wire;

  for (genvar g = 0; g < `CMS_NUM_OUTPUTS; g++)
  begin : g_out
    cms_sel_t code;
    logic pick;
    assign code = select_word[`CMS_SEL_BITS*g +: `CMS_SEL_BITS];
    assign sel0_wire[g] = code[0];
    assign sel1_wire[g] = code[1];

    // choose among three feeds
    // each lane has its own process variable, so no vector has two writers
    always_comb
    begin
      case (code)
        `CMS_SEL_LOW_FEED: pick = i_feed_low_range[g];
        `CMS_SEL_MID_FEED: pick = i_feed_mid_range[g];
        `CMS_SEL_HIGH_FEED: pick = i_feed_high_range[g];
        default: pick = 1'b0;
      endcase
    end
    assign comb_out_next[g] = pick;
  end

  // register selector outputs; select lines come straight from the store
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      comb_out_reg <= 16'h0000;
    end
    else
    begin
      comb_out_reg <= comb_out_next;
    end
  end

  // ==========================================================
  // card fan-out: re-driven copies of the synchronised link
  cms_link_s link_next;
  cms_link_s link_reg;

  always_comb
  begin
    link_next.data = data_s;
    link_next.clock = clock_s;
    link_next.strobe = strobe_s;
    link_next.vertical_trigger = vt_s;
  end

  // one register feeds all three cards so they see identical timing
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      link_reg <= '0;
    end
    else
    begin
      link_reg <= link_next;
    end
  end

  // ==========================================================
  // outputs
  assign o_combined_out = comb_out_reg;
  assign o_out_select_bit0 = sel0_wire;
  assign o_out_select_bit1 = sel1_wire;
  assign o_selector_shift_clock = shift_pulse_reg;
  assign o_frame_active = (state_reg == CMS_ST_SHIFT);
  assign o_frame_bit_count = count_reg;
  assign o_card_link = {link_reg, link_reg, link_reg};
  assign o_card_position_id = {`CMS_CARD2_ID, `CMS_CARD1_ID, `CMS_CARD0_ID};

endmodule : cms_matrix_control

// *** bench/cms_matrix_control_properties.sv ***
// assertions on the combiner matrix control ports
`include "cms_defs.svh"
module cms_mc_properties
  import cms_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ctl_serial_data,
  input wire logic i_ctl_serial_clock,
  input wire logic i_ctl_serial_strobe,
  input wire logic i_vertical_trigger,
  input wire logic [15:0] i_feed_low_range,
  input wire logic [15:0] i_feed_mid_range,
  input wire logic [15:0] i_feed_high_range,
  input wire logic [15:0] o_combined_out,
  input wire logic [15:0] o_out_select_bit0,
  input wire logic [15:0] o_out_select_bit1,
  input wire logic o_selector_shift_clock,
  input wire logic o_frame_active,
  input wire cms_link_s [2:0] o_card_link,
  input wire logic [2:0][1:0] o_card_position_id
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic [15:0] exp_mux;
  // ==========
  // reference selector, ground modelled as zero
  always_comb
  begin
    for (int k = 0; k < 16; k++)
      case ({o_out_select_bit1[k], o_out_select_bit0[k]})
        2'h0: exp_mux[k] = i_feed_low_range[k];
        2'h1: exp_mux[k] = i_feed_mid_range[k];
        2'h2: exp_mux[k] = i_feed_high_range[k];
        default: exp_mux[k] = 1'h0;
      endcase
  end
  sequence s_edge;
    $rose(i_ctl_serial_clock) && i_ctl_serial_strobe && o_frame_active;
  endsequence
  sequence s_pulse;
    o_selector_shift_clock;
  endsequence
  // ==========
  // checks
  a_pulse_cause: assert property (s_edge |-> ##3 s_pulse)
    else $error("no shift pulse after serial clock edge");
  a_pulse_width: assert property (s_pulse |=> !o_selector_shift_clock)
    else $error("shift pulse longer than one cycle");
  a_idle_quiet: assert property (!i_ctl_serial_strobe [*8] |-> !o_selector_shift_clock)
    else $error("shift pulse outside strobe frame");
  a_select_hold: assert property ($changed({o_out_select_bit1, o_out_select_bit0}) |->
    $past(i_vertical_trigger, 4) && !$past(i_vertical_trigger, 5))
    else $error("select changed without trigger");
  // frame state follows the strobe pin through two sync flops and the state register
  a_frame_track: assert property ($past(i_reset_n, 3) |->
    o_frame_active == $past(i_ctl_serial_strobe, 3))
    else $error("frame active does not follow strobe");
  a_mux_route: assert property (o_combined_out == $past(exp_mux))
    else $error("combined output not from selected feed");
  a_ground_zero: assert property
    ((o_combined_out & $past(o_out_select_bit0 & o_out_select_bit1)) == 16'h0000)
    else $error("grounded output not zero");
  a_link_copy: assert property ($past(i_reset_n, 3) |-> o_card_link[0] ==
    {$past(i_ctl_serial_data, 3), $past(i_ctl_serial_clock, 3), $past(i_ctl_serial_strobe, 3),
    $past(i_vertical_trigger, 3)} && o_card_link[1] == o_card_link[0]
    && o_card_link[2] == o_card_link[0])
    else $error("card link not a delayed copy");
  a_card_ids: assert property (o_card_position_id == {2'h2, 2'h1, 2'h0})
    else $error("card position ids wrong");
endmodule : cms_mc_properties

bind cms_matrix_control cms_mc_properties u_props (.i_clk_sys, .i_reset_n, .i_ctl_serial_data,
  .i_ctl_serial_clock, .i_ctl_serial_strobe, .i_vertical_trigger, .i_feed_low_range,
  .i_feed_mid_range, .i_feed_high_range, .o_combined_out, .o_out_select_bit0,
  .o_out_select_bit1, .o_selector_shift_clock, .o_frame_active, .o_card_link,
  .o_card_position_id);

// *** bench/cms_ctl_model.sv ***
// control processor model sending the serial selector stream
module cms_ctl_model
(
  input wire logic i_clk_sys,
  output logic o_data,
  output logic o_clock,
  output logic o_strobe,
  output logic o_vt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_data, o_clock, o_strobe, o_vt} = 4'h0;
  // released data line wanders outside frames so stale bits never look valid
  always @(posedge i_clk_sys)
    if (!o_strobe)
      o_data <= ~o_data;
  // ==========
  // strobe framed msb first
  task send(input logic [63:0] w, input int n, input int h);
    o_strobe <= 1'h1;
    repeat (3) @(posedge i_clk_sys);
    for (int i = n - 1; i >= 0; i--)
    begin
      o_data <= w[i];
      repeat (h) @(posedge i_clk_sys);
      o_clock <= 1'h1;
      repeat (h) @(posedge i_clk_sys);
      o_clock <= 1'h0;
    end
    repeat (h) @(posedge i_clk_sys);
    o_strobe <= 1'h0;
    @(posedge i_clk_sys);
  endtask : send
  // clock edges with no strobe, sent only on command
  task stray(input int k);
    repeat (k * 2)
    begin
      o_clock <= ~o_clock;
      repeat (3) @(posedge i_clk_sys);
    end
  endtask : stray
  task trig();
    o_vt <= 1'h1;
    repeat (4) @(posedge i_clk_sys);
    o_vt <= 1'h0;
    repeat (4) @(posedge i_clk_sys);
  endtask : trig
endmodule : cms_ctl_model

// *** bench/cms_matrix_control_tb.sv ***
// self-checking bench for the combiner matrix serial control block
`include "cms_defs.svh"
module cms_matrix_control_tb;
  import cms_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'h0;
  logic i_reset_n = 1'h0;
  logic i_ctl_serial_data, i_ctl_serial_clock, i_ctl_serial_strobe, i_vertical_trigger;
  logic [15:0] i_feed_low_range = 16'h0000;
  logic [15:0] i_feed_mid_range = 16'h0000;
  logic [15:0] i_feed_high_range = 16'h0000;
  logic [15:0] o_combined_out, o_out_select_bit0, o_out_select_bit1;
  logic o_selector_shift_clock, o_frame_active;
  logic [5:0] o_frame_bit_count;
  cms_link_s [2:0] o_card_link;
  logic [2:0][1:0] o_card_position_id;
  int err_total = 0;
  int checked = 0;
  logic [5:0] cnt_q[$];
  logic [31:0] sr;
  logic [31:0] seed = 32'h00018421;
  cms_matrix_control u_cms_matrix_control (.i_clk_sys, .i_reset_n, .i_ctl_serial_data,
    .i_ctl_serial_clock, .i_ctl_serial_strobe, .i_vertical_trigger, .i_feed_low_range,
    .i_feed_mid_range, .i_feed_high_range, .o_combined_out, .o_out_select_bit0,
    .o_out_select_bit1, .o_selector_shift_clock, .o_frame_active, .o_frame_bit_count,
    .o_card_link, .o_card_position_id);
  cms_ctl_model u_cms_ctl_model (.i_clk_sys, .o_data(i_ctl_serial_data),
    .o_clock(i_ctl_serial_clock), .o_strobe(i_ctl_serial_strobe), .o_vt(i_vertical_trigger));
  initial forever #2 i_clk_sys = ~i_clk_sys;
  // ==========
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task give_verdict;
    $display("checked %0d bad %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task rst;
    i_reset_n <= 1'h0;
    repeat (3) @(posedge i_clk_sys);
    chk("rst_sel", {o_out_select_bit1, o_out_select_bit0}, 32'hFFFFFFFF);
    chk("rst_out", o_combined_out, 32'h0);
    // each card must see its own slot number to pick its input range
    for (int c = 0; c < 3; c++)
      chk("card_id", o_card_position_id[c], c);
    i_reset_n <= 1'h1;
    @(posedge i_clk_sys);
    sr = 32'hFFFFFFFF;
  endtask : rst
  // one frame, trigger, then the expected selector state
  task frame(input logic [63:0] w, input int n);
    logic [15:0] b0, b1, ex, lo, mi, hi;
    lo = seed[15:0];
    mi = seed[31:16];
    seed = xs(seed);
    hi = seed[15:0];
    i_feed_low_range <= lo;
    i_feed_mid_range <= mi;
    i_feed_high_range <= hi;
    for (int i = 1; i <= n; i++)
      cnt_q.push_back((i > 32) ? 6'h20 : 6'(i));
    for (int i = n - 1; i >= 0; i--)
      sr = {sr[30:0], w[i]};
    u_cms_ctl_model.send(w, n, 3 + int'(seed[16]));
    u_cms_ctl_model.trig();
    for (int k = 0; k < 16; k++)
    begin
      b0[k] = sr[2 * k];
      b1[k] = sr[2 * k + 1];
      ex[k] = b1[k] ? (b0[k] ? 1'h0 : hi[k]) : (b0[k] ? mi[k] : lo[k]);
    end
    chk("sel0", o_out_select_bit0, b0);
    chk("sel1", o_out_select_bit1, b1);
    chk("out", o_combined_out, ex);
    $display("frame of %0d bits done", n);
  endtask : frame
  // ==========
  // pulse watcher takes the oldest expected count
  always @(posedge i_clk_sys)
    if (o_selector_shift_clock === 1'h1)
    begin
      @(posedge i_clk_sys);
      if (cnt_q.size() == 0)
        chk("stray", 1, 0);
      else
        chk("count", o_frame_bit_count, cnt_q.pop_front());
    end
  initial
  begin
    repeat (100000) @(posedge i_clk_sys);
    err_total++;
    give_verdict;
  end
  initial
  begin
    rst;
    frame(64'hE4E4E4E4, 32);
    frame(64'h5A, 8);
    frame(64'h3_1B1B_2727, 34);
    u_cms_ctl_model.stray(4);
    frame(64'h0, 32);
    rst;
    repeat (4)
    begin
      seed = xs(seed);
      frame({32'h0, seed}, 32);
    end
    repeat (20) @(posedge i_clk_sys);
    chk("left", cnt_q.size(), 0);
    give_verdict;
  end
endmodule : cms_matrix_control_tb
